/* gpc_port.sv */
// One general purpose port controller with APB register access.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - One controller per group, width set per group.
// - Register bit n maps to pin n.
// - Drive pins only when general function selected.
// - Soft reset returns registers to defaults, except clock enable; raw status takes that cycle's edges.
// - After reset all pins are inputs.
// - Pin level register returns sampled pins.
// - Whole-word write sets all output data.
// - Set and clear writes change one-bits only.
// - Output data register reads back data.
// - All logic runs on bus clock.
// - Idle: configurable, state kept across gating.
// - Stop: configuration held without clock.
// - Both edges on every pin are events.
// - Edges detected in any pin use.
// - Edge sets sticky raw status bit.
// - Mask bit one enables pin interrupt.
// - Writing one to clear drops pending bit.
// - Port drives its own interrupt request.
// - Ports spaced 0x1000, same offsets.
// - Enable-set makes output, enable-clear input.
// - Masked status is mask AND raw.
// - Clock enable survives soft reset.
module gpc_port #(
  parameter int          PIN_COUNT = 32,
  parameter logic [25:0] IDENT     = gpc_pkg::IDENT_DEFAULT
) (
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pads and pin-function selector.
  input  wire logic [31:0]       i_pin,
  input  wire logic [63:0]       i_pin_function_selector,
  output gpc_pkg::gpc_pad_s      o_pad,
  output logic      [31:0]       o_block_clock_on,
  // Interrupt request.
  output logic                   o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [31:0] valid_mask;
  logic [31:0] dir;
  logic [31:0] out_data;
  logic [31:0] irq_mask;
  logic [31:0] raw_stat;
  logic [31:0] masked;
  logic [31:0] sync1;
  logic [31:0] sync2;
  logic [31:0] prev;
  logic [31:0] edges;
  logic        clk_on;
  logic        wr;
  logic        soft_rst;
  logic [31:0] wdat;
  logic [31:0] gp_sel;

  // Writes complete in the access phase; the slave never waits.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Implemented pin bits; the rest stay zero everywhere.
  assign valid_mask = (PIN_COUNT >= 32) ? 32'hffff_ffff
                    : ((32'h0000_0001 << PIN_COUNT) - 32'h0000_0001);
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign wr         = psel & penable & pwrite;
  assign wdat       = pwdata & valid_mask;
  assign soft_rst   = wr & hit(paddr, gpc_pkg::OFF_SOFT_RST)
                    & pwdata[gpc_pkg::BIT_SOFT_RST];

  //////////////////////////////////////////////////////////////////////////////
  // Clock enable control, untouched by soft reset.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_on <= gpc_pkg::RST_CLK_ON;
    end else if (wr && hit(paddr, gpc_pkg::OFF_CLK_EN)) begin
      clk_on <= pwdata[gpc_pkg::BIT_CLK_ON];
    end
  end
  // Offered to the clock gate; software sets it before configuring.
  assign o_block_clock_on = {31'h0, clk_on};

  //////////////////////////////////////////////////////////////////////////////
  // Direction register; input after any reset.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dir <= gpc_pkg::RST_WORD;
    end else if (soft_rst) begin
      dir <= gpc_pkg::RST_WORD;
    end else if (wr && hit(paddr, gpc_pkg::OFF_OE_SET)) begin
      dir <= dir | wdat;
    end else if (wr && hit(paddr, gpc_pkg::OFF_OE_CLR)) begin
      dir <= dir & ~wdat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output data register.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_data <= gpc_pkg::RST_WORD;
    end else if (soft_rst) begin
      out_data <= gpc_pkg::RST_WORD;
    end else if (wr && hit(paddr, gpc_pkg::OFF_OUT_WRITE)) begin
      out_data <= wdat;
    end else if (wr && hit(paddr, gpc_pkg::OFF_OUT_SET)) begin
      out_data <= out_data | wdat;
    end else if (wr && hit(paddr, gpc_pkg::OFF_OUT_CLR)) begin
      out_data <= out_data & ~wdat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt mask register.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_mask <= gpc_pkg::RST_WORD;
    end else if (soft_rst) begin
      irq_mask <= gpc_pkg::RST_WORD;
    end else if (wr && hit(paddr, gpc_pkg::OFF_IRQ_MASK)) begin
      irq_mask <= wdat;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and edge detector; registers hold without clock.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1 <= gpc_pkg::RST_WORD;
      sync2 <= gpc_pkg::RST_WORD;
      prev  <= gpc_pkg::RST_WORD;
    end else begin
      sync1 <= i_pin & valid_mask;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  // Any change in either direction, whatever the pin's use.
  assign edges = (sync2 ^ prev) & valid_mask;

  //////////////////////////////////////////////////////////////////////////////
  // Raw status; a new edge wins over a clear in the same cycle.

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      raw_stat <= gpc_pkg::RST_WORD;
    end else if (soft_rst) begin
      raw_stat <= edges;
    end else if (wr && hit(paddr, gpc_pkg::OFF_IRQ_CLR)) begin
      raw_stat <= (raw_stat & ~wdat) | edges;
    end else begin
      raw_stat <= raw_stat | edges;
    end
  end

  // Masked status and request line.
  assign masked = raw_stat & irq_mask;
  assign o_irq  = |masked;

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive, only for pins given the general function.

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      gp_sel[i] = (i_pin_function_selector[2*i +: 2] == gpc_pkg::FUNC_GPIO);
    end
  end
  // Configuration sits in flops, so gating the clock keeps it.
  assign o_pad.out_en  = dir & gp_sel;
  assign o_pad.out_val = out_data & gp_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; same offsets in every port.

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (paddr)
        gpc_pkg::OFF_IDENT:     prdata = {6'h00, IDENT};
        gpc_pkg::OFF_CLK_EN:    prdata = {31'h0, clk_on};
        gpc_pkg::OFF_IRQ_MASK:  prdata = irq_mask;
        gpc_pkg::OFF_RAW_STAT:  prdata = raw_stat;
        gpc_pkg::OFF_MASK_STAT: prdata = masked;
        gpc_pkg::OFF_DIR_STAT:  prdata = dir;
        gpc_pkg::OFF_OUT_READ:  prdata = out_data;
        gpc_pkg::OFF_PIN_READ:  prdata = sync2;
        default:                prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

/* gpc_pkg.sv */
// Package with register map, field layout and carrier types of the port.
package gpc_pkg;

  // Register offsets (byte addresses within one port controller).
  localparam logic [11:0] OFF_IDENT      = 12'h000;
  localparam logic [11:0] OFF_CLK_EN     = 12'h004;
  localparam logic [11:0] OFF_SOFT_RST   = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h00c;
  localparam logic [11:0] OFF_RAW_STAT   = 12'h010;
  localparam logic [11:0] OFF_MASK_STAT  = 12'h014;
  localparam logic [11:0] OFF_IRQ_CLR    = 12'h018;
  localparam logic [11:0] OFF_OE_SET     = 12'h01c;
  localparam logic [11:0] OFF_OE_CLR     = 12'h020;
  localparam logic [11:0] OFF_DIR_STAT   = 12'h024;
  localparam logic [11:0] OFF_OUT_WRITE  = 12'h028;
  localparam logic [11:0] OFF_OUT_SET    = 12'h02c;
  localparam logic [11:0] OFF_OUT_CLR    = 12'h030;
  localparam logic [11:0] OFF_OUT_READ   = 12'h034;
  localparam logic [11:0] OFF_PIN_READ   = 12'h038;

  // Spacing of the four port controllers in the system map.
  localparam logic [31:0] PORT_STRIDE    = 32'h0000_1000;

  // Field positions.
  localparam int          BIT_CLK_ON     = 0;
  localparam int          BIT_SOFT_RST   = 0;
  localparam int          IDENT_WIDTH    = 26;

  // Reset values.
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic        RST_CLK_ON     = 1'b0;

  // Arbitrary neutral identification value.
  localparam logic [25:0] IDENT_DEFAULT  = 26'h000_0a5c;

  // Pin-function code that selects the general purpose function.
  localparam logic [1:0]  FUNC_GPIO      = 2'h0;

  // Per-pin output drive towards the pad.
  typedef struct packed {
    logic [31:0] out_val;
    logic [31:0] out_en;
  } gpc_pad_s;

endpackage

/* gpc_port_props.sv */
// Checker of the port controller's bus, pad and interrupt behaviour.
`timescale 1ns/1ps
module gpc_port_props (
  // Clock, reset and bus.
  input wire logic              i_clk, i_nrst, psel, penable, pwrite,
  input wire logic              pready, pslverr, o_irq,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata, prdata, i_pin, o_block_clock_on,
  // Pads and function selector.
  input wire logic [63:0]       i_pin_function_selector,
  input wire gpc_pkg::gpc_pad_s o_pad
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Write taken at the access edge, and pin 0 in general purpose use.
  wire wr = psel && penable && pwrite;
  wire g0 = i_pin_function_selector[1:0] == gpc_pkg::FUNC_GPIO;
  wire keep = o_irq && !(wr && (paddr == gpc_pkg::OFF_IRQ_CLR ||
    paddr == gpc_pkg::OFF_SOFT_RST || paddr == gpc_pkg::OFF_IRQ_MASK));
  // Soft reset request accepted on the bus.
  sequence srst_s;
    wr && paddr == gpc_pkg::OFF_SOFT_RST && pwdata[gpc_pkg::BIT_SOFT_RST];
  endsequence
  chk_bus_answer: assert property (pready && !pslverr)
    else $error("Bus answer late or in error.");
  chk_pad_gate: assert property (!g0 |-> !o_pad.out_en[0] &&
    !o_pad.out_val[0]) else $error("Pad driven outside general use.");
  chk_oe_set: assert property (wr && paddr == gpc_pkg::OFF_OE_SET &&
    pwdata[0] && g0 |=> !g0 || o_pad.out_en[0])
    else $error("Output enable did not take.");
  chk_oe_clear: assert property (wr && paddr == gpc_pkg::OFF_OE_CLR &&
    pwdata[0] |=> !o_pad.out_en[0]) else $error("Output stayed enabled.");
  chk_out_word: assert property (wr && paddr == gpc_pkg::OFF_OUT_WRITE
    |=> !g0 || o_pad.out_val[0] == $past(pwdata[0]))
    else $error("Output data word not driven.");
  chk_irq_sticky: assert property (keep |=> o_irq)
    else $error("Interrupt dropped without a clear.");
  chk_clk_write: assert property (wr && paddr == gpc_pkg::OFF_CLK_EN
    |=> o_block_clock_on == {31'h0, $past(pwdata[0])})
    else $error("Clock enable bit wrong.");
  chk_soft_reset: assert property (srst_s |=> o_pad == '0 &&
    $stable(o_block_clock_on)) else $error("Soft reset left state.");
endmodule

/* gpc_pad_model.sv */
// Pad model: each pin shows the driven level or the board level.
`timescale 1ns/1ps
module gpc_pad_model (
  // Pad drive from the port and level from the board.
  input  wire gpc_pkg::gpc_pad_s i_pad,
  input  wire logic [31:0]       i_board,
  // Resolved pin level.
  output logic      [31:0]       o_pin
);
  // A driven pin follows its output data, an undriven one the board.
  assign o_pin = (i_pad.out_en & i_pad.out_val) | (~i_pad.out_en & i_board);
endmodule

/* gpc_port_bench.sv */
// Self-checking bench of one port controller.
`timescale 1ns/1ps
module gpc_port_bench;
  logic i_clk = 0, i_nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, o_irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, board = '0, pin, q, clk_on;
  logic [63:0] sel = '0;
  gpc_pkg::gpc_pad_s pad;
  int failures = 0, checks_done = 0, cycles = 0;
  always #5 i_clk = ~i_clk;
  gpc_port DUT (.i_clk, .i_nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata(q), .pready, .pslverr, .i_pin(pin),
    .i_pin_function_selector(sel), .o_pad(pad),
    .o_block_clock_on(clk_on), .o_irq);
  gpc_pad_model u_pads (.i_pad(pad), .i_board(board), .o_pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  // Ends the run with the verdict.
  task automatic print_verdict;
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic cmp(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus transfer; read data is taken at the accepting edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1 && cycles < 4000);
    r = q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    cmp(n, e, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, an unmapped and a write-only place read zero.
  task automatic t_reset;
    logic [11:0] ofs [7] = '{gpc_pkg::OFF_CLK_EN, gpc_pkg::OFF_IRQ_MASK,
      gpc_pkg::OFF_RAW_STAT, gpc_pkg::OFF_DIR_STAT, gpc_pkg::OFF_OUT_READ,
      gpc_pkg::OFF_OE_SET, 12'h100};
    foreach (ofs[i]) rd("reset_reg", ofs[i], 32'h0);
    rd("ident", gpc_pkg::OFF_IDENT, {6'h0, gpc_pkg::IDENT_DEFAULT});
    cmp("pad_reset", 32'h0, pad.out_en);
  endtask
  // Direction, output data and pin levels, with one pin taken away.
  task automatic t_output;
    wr(gpc_pkg::OFF_CLK_EN, 32'h1);
    @(negedge i_clk);
    cmp("clock_on", 32'h1, clk_on);
    wr(gpc_pkg::OFF_OE_SET, 32'h0000_ffff);
    wr(gpc_pkg::OFF_OE_CLR, 32'h0000_00fe);
    rd("direction", gpc_pkg::OFF_DIR_STAT, 32'h0000_ff01);
    wr(gpc_pkg::OFF_OUT_WRITE, 32'ha5a5_5a5a);
    wr(gpc_pkg::OFF_OUT_SET, 32'h0000_000f);
    wr(gpc_pkg::OFF_OUT_CLR, 32'h0000_5000);
    rd("out_data", gpc_pkg::OFF_OUT_READ, 32'ha5a5_0a5f);
    board <= 32'h1234_5678;
    sel[1:0] <= 2'h1;
    repeat (5) @(posedge i_clk);
    cmp("pad_en", 32'h0000_ff00, pad.out_en);
    cmp("pad_val", 32'ha5a5_0a5e, pad.out_val);
    sel[1:0] <= gpc_pkg::FUNC_GPIO;
    repeat (5) @(posedge i_clk);
    rd("pins", gpc_pkg::OFF_PIN_READ, 32'h1234_0a79);
  endtask
  // Edges on input pins, masking and clearing.
  task automatic t_irq;
    wr(gpc_pkg::OFF_OE_CLR, 32'h1);
    repeat (5) @(posedge i_clk);
    wr(gpc_pkg::OFF_IRQ_CLR, 32'hffff_ffff);
    rd("raw_clear", gpc_pkg::OFF_RAW_STAT, 32'h0);
    wr(gpc_pkg::OFF_IRQ_MASK, 32'h3);
    board <= board ^ 32'h11;
    repeat (5) @(posedge i_clk);
    rd("raw_rise", gpc_pkg::OFF_RAW_STAT, 32'h11);
    rd("masked", gpc_pkg::OFF_MASK_STAT, 32'h1);
    cmp("irq_on", 32'h1, {31'h0, o_irq});
    wr(gpc_pkg::OFF_IRQ_CLR, 32'h1);
    rd("raw_left", gpc_pkg::OFF_RAW_STAT, 32'h10);
    board <= board ^ 32'h1;
    repeat (5) @(posedge i_clk);
    rd("raw_fall", gpc_pkg::OFF_RAW_STAT, 32'h11);
    wr(gpc_pkg::OFF_IRQ_MASK, 32'h0);
    @(negedge i_clk);
    cmp("irq_off", 32'h0, {31'h0, o_irq});
  endtask
  // Soft reset clears the port but keeps the clock enable.
  task automatic t_soft_reset;
    wr(gpc_pkg::OFF_OE_CLR, 32'hffff_ffff);
    repeat (5) @(posedge i_clk);
    wr(gpc_pkg::OFF_SOFT_RST, 32'h1);
    rd("dir_sr", gpc_pkg::OFF_DIR_STAT, 32'h0);
    rd("raw_sr", gpc_pkg::OFF_RAW_STAT, 32'h0);
    rd("out_sr", gpc_pkg::OFF_OUT_READ, 32'h0);
    rd("clk_sr", gpc_pkg::OFF_CLK_EN, 32'h1);
  endtask
  // Cuts a hang short.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_output();
    t_irq();
    t_soft_reset();
    print_verdict();
  end
endmodule
bind gpc_port gpc_port_props u_props (.i_clk, .i_nrst, .psel, .penable,
  .pwrite, .pready, .pslverr, .o_irq, .paddr, .pwdata, .prdata, .i_pin,
  .o_block_clock_on, .i_pin_function_selector, .o_pad);
